// ### include/plcc_cfg.svh
// Constants for the single-wire pulse-count LED current controller
// What this block does
// - Level register counts enable/data rising edges
// - New level applied after 500 us high
// - Line low over 500 us enters shutdown
// - Shutdown clears the level register
// - Shutdown turns all three sinks off
// - First edge from shutdown selects level one
// - Each further edge advances level one step, up to 32
// - Levels map to published current steps
// - All three sinks share one level
// - Edges accepted at up to 1 MHz
`ifndef PLCC_CFG_SVH
`define PLCC_CFG_SVH

// Clock period of CORE_CLK in ns
`define PLCC_CLK_PERIOD_NS 25
// Latch pause and off timeout in ns
`define PLCC_LATCH_PAUSE_TIME_NS 500000
`define PLCC_OFF_TIME_NS 500000
// Timeout counts in cycles, rounded down
`define PLCC_LATCH_CYCLES (`PLCC_LATCH_PAUSE_TIME_NS / `PLCC_CLK_PERIOD_NS)
`define PLCC_OFF_CYCLES (`PLCC_OFF_TIME_NS / `PLCC_CLK_PERIOD_NS)
// Level field values
`define PLCC_LEVEL_RESET 6'h00
`define PLCC_LEVEL_FIRST 6'h01
`define PLCC_LEVEL_MAX 6'h20
// Timer width and saturation value
`define PLCC_TIMER_W 16
`define PLCC_TIMER_SAT 16'hffff
// Number of current sinks
`define PLCC_SINKS 3

`endif

// ### include/plcc_pkg.sv
// Types shared by the LED current controller modules
package plcc_pkg;
    // Brightness level, 0 means off, 1 to 32 valid
    typedef logic [5:0] plcc_level_t;
    // Sink current in tenths of a milliamp
    typedef logic [8:0] plcc_current_t;
    // Driver operating mode
    typedef enum logic {
        PLCC_SHUTDOWN,
        PLCC_ACTIVE
    } plcc_mode_t;
endpackage

// ### core/plcc_level_map.sv
// Level to sink current lookup for the LED current controller
`timescale 1ns/1ps
`default_nettype none
`include "plcc_cfg.svh"

module plcc_level_map (
    input  wire plcc_pkg::plcc_level_t   level,
    output var  plcc_pkg::plcc_current_t current
);
    import plcc_pkg::*;

    // Current per level in 0.1 mA, entry 0 is off
    localparam plcc_current_t STEP_TABLE [0:32] = '{
        9'h000, 9'h12e, 9'h124, 9'h11b, 9'h111, 9'h107, 9'h0fd, 9'h0f4, 9'h0ea,
        9'h0e0, 9'h0d6, 9'h0cd, 9'h0c3, 9'h0b9, 9'h0af, 9'h0a6, 9'h09c,
        9'h092, 9'h088, 9'h07f, 9'h075, 9'h06b, 9'h061, 9'h058, 9'h04e,
        9'h044, 9'h03a, 9'h031, 9'h027, 9'h01d, 9'h013, 9'h00a, 9'h005
    };

    always_comb begin
        if (level > `PLCC_LEVEL_MAX) begin
            // Out-of-range code gives no current
            current = 9'h000;
        end else begin
            current = STEP_TABLE[level];
        end
    end
endmodule
`default_nettype wire

// ### core/plcc_top.sv
// Single-wire pulse-count LED current controller, device side
`timescale 1ns/1ps
`default_nettype none
`include "plcc_cfg.svh"

module plcc_top #(
    parameter int LATCH_CYCLES = `PLCC_LATCH_CYCLES, // Latch pause in cycles
    parameter int OFF_CYCLES   = `PLCC_OFF_CYCLES    // Off timeout in cycles
) (
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST,
    input  wire logic                    EN_DATA,
    output var  logic                    SINK_OUT_ONE,
    output var  logic                    SINK_OUT_TWO,
    output var  logic                    SINK_OUT_THREE,
    output var  plcc_pkg::plcc_level_t   SINK_LEVEL,
    output var  plcc_pkg::plcc_current_t SINK_CURRENT,
    output var  logic                    DRIVER_ON
);
    import plcc_pkg::*;

    // Pin synchroniser stages
    logic                        en_s1_q;      // First stage, read only by second
    logic                        en_s2_q;      // Synchronised line level
    logic                        en_dly_q;     // Delayed copy for edge detect
    // Edge and timeout decode
    logic                        rise;         // Rising edge of the line
    logic                        any_edge;     // Any edge of the line
    logic                        latch_hit;    // Line high for the latch pause
    logic                        off_hit;      // Line low for the off timeout
    // Core state
    plcc_mode_t                  mode_q;       // Shutdown or active
    plcc_level_t                 count_q;      // Edge-counted level register
    logic [`PLCC_TIMER_W-1:0]    timer_q;      // Cycles since last line edge
    // Applied outputs
    plcc_level_t                 level_q;      // Level shown on the sinks
    plcc_current_t               current_q;    // Current shown on the sinks
    logic [`PLCC_SINKS-1:0]      sink_en_q;    // Per-sink switch enables
    logic                        drv_on_q;     // Driver powered flag
    plcc_current_t               map_current;  // Lookup of the counted level

    // Two-flop synchroniser on the pin
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            en_dly_q <= 1'b0;
        end else begin
            en_s1_q <= EN_DATA;
            en_s2_q <= en_s1_q;
            en_dly_q <= en_s2_q;
        end
    end

    assign rise     = en_s2_q & ~en_dly_q;
    assign any_edge = en_s2_q ^ en_dly_q;

    assign latch_hit = (mode_q == PLCC_ACTIVE) && en_s2_q && !any_edge
                       && (timer_q == `PLCC_TIMER_W'(LATCH_CYCLES - 1));
    assign off_hit   = (mode_q == PLCC_ACTIVE) && !en_s2_q && !any_edge
                       && (timer_q == `PLCC_TIMER_W'(OFF_CYCLES - 1));

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            timer_q <= '0;
        end else if (any_edge) begin
            // Fresh interval begins
            timer_q <= '0;
        end else if (timer_q != `PLCC_TIMER_SAT) begin
            // Count, holding at the top
            timer_q <= timer_q + 1'b1;
        end
    end

    // Mode: rise wakes, off timeout sleeps
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mode_q <= PLCC_SHUTDOWN;
        end else begin
            unique case (mode_q)
                PLCC_SHUTDOWN: begin
                    if (rise) begin
                        mode_q <= PLCC_ACTIVE;
                    end
                end
                PLCC_ACTIVE: begin
                    if (off_hit) begin
                        mode_q <= PLCC_SHUTDOWN;
                    end
                end
            endcase
        end
    end

    // Level register counted from rising edges
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            count_q <= `PLCC_LEVEL_RESET;
        end else if (off_hit) begin
            count_q <= `PLCC_LEVEL_RESET;
        end else if (rise && mode_q == PLCC_SHUTDOWN) begin
            count_q <= `PLCC_LEVEL_FIRST;
        end else if (rise && count_q < `PLCC_LEVEL_MAX) begin
            count_q <= count_q + 1'b1;
        end
        // at the top further edges hold
    end

    // Lookup of the counted level
    plcc_level_map u_map (
        .level   (count_q),
        .current (map_current)
    );

    a_map_lookup: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (count_q == 6'h01 |-> map_current == 9'h12e)
        and (count_q == 6'h10 |-> map_current == 9'h09c)
        and (count_q == 6'h1f |-> map_current == 9'h00a))
        else $error("level lookup gives wrong current");

    // Applied level and current, updated at latch, cleared at off timeout
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            level_q   <= `PLCC_LEVEL_RESET;
            current_q <= '0;
        end else if (off_hit) begin
            level_q   <= `PLCC_LEVEL_RESET;
            current_q <= '0;
        end else if (latch_hit) begin
            level_q   <= count_q;
            current_q <= map_current;
        end
    end

    // Driver powered flag follows the mode change
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            drv_on_q <= 1'b0;
        end else if (off_hit) begin
            drv_on_q <= 1'b0;
        end else if (rise) begin
            drv_on_q <= 1'b1;
        end
    end

    for (genvar g = 0; g < `PLCC_SINKS; g++) begin : g_sink
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                sink_en_q[g] <= 1'b0;
            end else if (off_hit) begin
                sink_en_q[g] <= 1'b0;
            end else if (latch_hit) begin
                // Conduct only for a nonzero level
                sink_en_q[g] <= (count_q != `PLCC_LEVEL_RESET);
            end
        end
    end

    // Ports straight from flops
    assign SINK_OUT_ONE   = sink_en_q[0];
    assign SINK_OUT_TWO   = sink_en_q[1];
    assign SINK_OUT_THREE = sink_en_q[2];
    assign SINK_LEVEL     = level_q;
    assign SINK_CURRENT   = current_q;
    assign DRIVER_ON      = drv_on_q;

    a_latch_applies: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        latch_hit |=> (SINK_LEVEL == $past(count_q)) && (SINK_CURRENT == $past(map_current)))
        else $error("latched level differs from counted level");

    // sink level moves only at latch or off
    a_level_stable: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $changed(SINK_LEVEL) |-> $past(latch_hit) || $past(off_hit))
        else $error("sink level changed without latch or off");

    a_off_enters: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (mode_q == PLCC_ACTIVE && !en_s2_q && !any_edge
         && timer_q == `PLCC_TIMER_W'(OFF_CYCLES - 1))
        |=> (mode_q == PLCC_SHUTDOWN) && (count_q == `PLCC_LEVEL_RESET) && !DRIVER_ON)
        else $error("off timeout did not shut down and clear");

    a_shut_sinks_off: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        mode_q == PLCC_SHUTDOWN |-> !SINK_OUT_ONE && !SINK_OUT_TWO && !SINK_OUT_THREE)
        else $error("sink conducting in shutdown");

    a_first_edge_one: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (mode_q == PLCC_SHUTDOWN && rise) |=> (count_q == 6'h01) && (mode_q == PLCC_ACTIVE))
        else $error("first edge did not select level one");

    a_step_count: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (mode_q == PLCC_ACTIVE && rise && count_q < 6'h20) |=> count_q == $past(count_q) + 6'h01)
        else $error("edge did not advance level by one");

    a_top_holds: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (count_q == 6'h20 && rise) |=> count_q == 6'h20)
        else $error("level wrapped past 32");

    a_timer_restart: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        any_edge ##1 !any_edge |=> timer_q == 16'h0001)
        else $error("timer did not restart on edge");

    a_map_ends: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (SINK_LEVEL == 6'h01 |-> SINK_CURRENT == 9'h12e)
        and (SINK_LEVEL == 6'h20 |-> SINK_CURRENT == 9'h005))
        else $error("current step table mismatch");

    a_sinks_match: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (sink_en_q == 3'h0 || sink_en_q == 3'h7)
        && ((sink_en_q == 3'h7) == (SINK_LEVEL != 6'h00)))
        else $error("sinks disagree with each other or level");

    a_count_kept: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!rise && !off_hit) |=> $stable(count_q))
        else $error("level register changed without an edge");
endmodule
`default_nettype wire

// ### sim/plcc_host_model.sv
// Host model driving the single enable/data line of the controller
`timescale 1ns/1ps
`default_nettype none

module plcc_host_model #(
    parameter int PHASE_CYCLES = 20 // Cycles per high or low phase
) (
    input  wire logic core_clk, // Device clock, paces the line
    output var  logic en_data   // Enable/data line to the device
);
    // Line idles low, device in shutdown
    initial en_data = 1'b0;

    // Wait whole cycles, then step just past the edge
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            en_data = 1'b0;
            wait_cycles(PHASE_CYCLES);
            en_data = 1'b1;
            wait_cycles(PHASE_CYCLES);
        end
    endtask

    task automatic hold_high(input int n);
        en_data = 1'b1;
        wait_cycles(n);
    endtask

    task automatic hold_low(input int n);
        en_data = 1'b0;
        wait_cycles(n);
    endtask
endmodule

`default_nettype wire

// ### sim/testbench.sv
// Self-checking testbench for the LED current controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import plcc_pkg::*;
    localparam int LAT = 50; // Shortened latch pause
    localparam int OFF = 50; // Shortened off timeout
    // Expected current per level, tenths of a milliamp
    localparam plcc_current_t EXP_CUR [32] = '{
        9'h12e, 9'h124, 9'h11b, 9'h111, 9'h107, 9'h0fd, 9'h0f4, 9'h0ea,
        9'h0e0, 9'h0d6, 9'h0cd, 9'h0c3, 9'h0b9, 9'h0af, 9'h0a6, 9'h09c,
        9'h092, 9'h088, 9'h07f, 9'h075, 9'h06b, 9'h061, 9'h058, 9'h04e,
        9'h044, 9'h03a, 9'h031, 9'h027, 9'h01d, 9'h013, 9'h00a, 9'h005};
    logic          core_clk;     // Bench clock
    logic          rst;          // Synchronous reset
    logic          en_data;      // Line from the host model
    logic          sink_one;     // Sink switch one
    logic          sink_two;     // Sink switch two
    logic          sink_three;   // Sink switch three
    plcc_level_t   sink_level;   // Applied level
    plcc_current_t sink_current; // Applied current
    logic          driver_on;    // Driver powered
    int            n_errors = 0; // Mismatches seen
    int            num_checks = 0; // Comparisons made

    plcc_top #(
        .LATCH_CYCLES (LAT),
        .OFF_CYCLES   (OFF)
    ) plcc_top_i (
        .CORE_CLK       (core_clk),
        .RST            (rst),
        .EN_DATA        (en_data),
        .SINK_OUT_ONE   (sink_one),
        .SINK_OUT_TWO   (sink_two),
        .SINK_OUT_THREE (sink_three),
        .SINK_LEVEL     (sink_level),
        .SINK_CURRENT   (sink_current),
        .DRIVER_ON      (driver_on)
    );

    plcc_host_model plcc_host_model_i (
        .core_clk (core_clk),
        .en_data  (en_data)
    );

    // Count and report one mismatch
    task automatic fail(input string msg);
        n_errors++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask

    // Compare tasks, one per result kind
    task automatic cmp_lvl(input plcc_level_t got, input plcc_level_t exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("level %0d expected %0d", got, exp));
    endtask
    task automatic cmp_cur(input plcc_current_t got, input plcc_current_t exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("current %0d expected %0d", got, exp));
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp)
            fail($sformatf("%s is %b expected %b", what, got, exp));
    endtask

    // All outputs for an expected level and power state
    task automatic check_out(input int n, input logic on);
        cmp_lvl(sink_level, n[5:0]);
        cmp_cur(sink_current, (n == 0) ? 9'h000 : EXP_CUR[n-1]);
        cmp_bit(sink_one, n != 0, "sink one");
        cmp_bit(sink_two, n != 0, "sink two");
        cmp_bit(sink_three, n != 0, "sink three");
        cmp_bit(driver_on, on, "driver on");
    endtask

    // Every level from shutdown, old value held until the latch
    task automatic scen_levels();
        for (int n = 1; n <= 32; n++) begin
            plcc_host_model_i.hold_low(OFF + 8);
            check_out(0, 1'b0);
            plcc_host_model_i.burst(1);
            cmp_bit(driver_on, 1'b1, "driver on after first rise");
            plcc_host_model_i.burst(n - 1);
            plcc_host_model_i.hold_high(LAT - 30);
            check_out(0, 1'b1);
            plcc_host_model_i.hold_high(20);
            check_out(n, 1'b1);
        end
    endtask

    // Extra edges past the last step stay at the lowest current
    task automatic scen_saturate();
        plcc_host_model_i.hold_low(OFF + 8);
        plcc_host_model_i.burst(35);
        plcc_host_model_i.hold_high(40);
        check_out(32, 1'b1);
    endtask

    // A second burst keeps counting from the applied level
    task automatic scen_continue();
        plcc_host_model_i.hold_low(OFF + 8);
        plcc_host_model_i.burst(2);
        plcc_host_model_i.hold_high(40);
        check_out(2, 1'b1);
        plcc_host_model_i.burst(3);
        plcc_host_model_i.hold_high(40);
        check_out(5, 1'b1);
    endtask

    // Reset in mid-run clears all, a line high at release counts once
    task automatic scen_reset();
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        #2;
        check_out(0, 1'b0);
        rst = 1'b0;
        plcc_host_model_i.hold_high(60);
        check_out(1, 1'b1);
    endtask

    // Print counts and verdict, end the run
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Clock at 40 MHz
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Hang guard, well above the expected run length
    initial begin
        repeat (50000) @(posedge core_clk);
        fail("run did not finish in time");
        summarize();
    end

    // Reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        repeat (16) @(posedge core_clk);
        #2;
        rst = 1'b0;
        check_out(0, 1'b0);
        scen_levels();
        scen_saturate();
        scen_continue();
        scen_reset();
        summarize();
    end
endmodule

`default_nettype wire
